// File: src/adsp_splitter.sv
// address decode and access splitter between the core and its memories
// assumes targets hold off ack until they have taken or produced data
// Function
// - decode one flat 24-bit space
// - byte, word and quad transfers
// - two areas served in parallel
// - classify reserved low nonvolatile slots
// - ram ends at fixed top address
// - top 8 KB routed to io bus
// - absent io reads return all ones
// - absent io writes have no effect
// - everything else goes external
// - empty external space is undefined
// - big-endian, msb at the address
// - nvm and ram are 16 bits wide
// - io access sized per peripheral
// - external bus 8 or 16 bits
// - even word one, quad two accesses on 16-bit targets
// - odd word two, quad three accesses on 16-bit targets
`include "adsp_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module adsp_splitter (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // core channels, index 1 fetch, 0 data
  input wire adsp_pkg::adsp_cpu_req_type [1:0] cpu_req_i,
  output logic [1:0] cpu_busy_o,
  output adsp_pkg::adsp_cpu_rsp_type [1:0] cpu_rsp_o,
  // targets, indexed by area
  output adsp_pkg::adsp_mem_req_type [3:0] mem_req_o,
  input wire adsp_pkg::adsp_mem_rsp_type [3:0] mem_rsp_i,
  // configuration level
  input wire logic ext_wide_i
);

  // ----------------------------------------
  // decode functions
  // ----------------------------------------

  // area of an address, io first since it tops the map
  function automatic adsp_pkg::adsp_area_type area_of(input logic [23:0] a);
    if (a >= `ADSP_IO_BASE) begin
      area_of = adsp_pkg::AR_IO;
    end else if (a <= `ADSP_RAM_TOP && a >= `ADSP_RAM_BASE) begin
      area_of = adsp_pkg::AR_RAM;
    end else if (a <= `ADSP_NVM_TOP) begin
      area_of = adsp_pkg::AR_NVM;
    end else begin
      // nothing is promised for empty external space
      area_of = adsp_pkg::AR_EXT;
    end
  endfunction

  // slot of the reserved low block
  function automatic adsp_pkg::adsp_resv_type resv_of(input logic [23:0] a);
    if (a <= `ADSP_OPT_END) begin
      resv_of = adsp_pkg::RV_OPTION;
    end else if (a <= `ADSP_RST_END) begin
      resv_of = adsp_pkg::RV_RESET;
    end else if (a <= `ADSP_SYSX_END) begin
      resv_of = adsp_pkg::RV_SYSEXC;
    end else if (a <= `ADSP_TRAP_END) begin
      resv_of = adsp_pkg::RV_TRAP;
    end else if (a <= `ADSP_IRQ_END) begin
      resv_of = adsp_pkg::RV_IRQ;
    end else begin
      resv_of = adsp_pkg::RV_NONE;
    end
  endfunction

  // data path width of the target at an address
  function automatic logic wide_of(input logic [23:0] a, input logic ext_w);
    case (area_of(a))
      adsp_pkg::AR_NVM, adsp_pkg::AR_RAM: wide_of = 1'b1;
      adsp_pkg::AR_IO: wide_of = (a >= `ADSP_IO_WIDE_LO && a <= `ADSP_IO_WIDE_HI);
      default: wide_of = ext_w;
    endcase
  endfunction

  // bytes in a transfer
  function automatic logic [2:0] bytes_of(input adsp_pkg::adsp_size_type sz);
    case (sz)
      adsp_pkg::SZ_WORD: bytes_of = 3'h2;
      adsp_pkg::SZ_QUAD: bytes_of = 3'h4;
      default: bytes_of = 3'h1;
    endcase
  endfunction

  // bus cycles a transfer needs, used by the checks
  function automatic logic [2:0] cycles_of(input adsp_pkg::adsp_size_type sz,
                                           input logic odd, input logic w);
    if (!w) begin
      cycles_of = bytes_of(sz);
    end else if (sz == adsp_pkg::SZ_BYTE) begin
      cycles_of = 3'h1;
    end else if (sz == adsp_pkg::SZ_WORD) begin
      cycles_of = odd ? 3'h2 : 3'h1;
    end else begin
      cycles_of = odd ? 3'h3 : 3'h2;
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  adsp_pkg::adsp_state_type s_r; // all registered state except the check helpers
  adsp_pkg::adsp_state_type s_nxt; // its next value

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // acks retire first; a channel issues again only the cycle after,
  // which costs a cycle per access but keeps the owner logic trivial
  always_comb begin
    logic cw;
    logic two;
    logic oc;
    logic [7:0] bt;
    logic [15:0] hw;
    adsp_pkg::adsp_area_type ar;
    cw = 1'b0;
    two = 1'b0;
    oc = 1'b0;
    bt = 8'h00;
    hw = 16'h0000;
    ar = adsp_pkg::AR_NVM;
    s_nxt = s_r;
    s_nxt.rsp[0].done = 1'b0;
    s_nxt.rsp[1].done = 1'b0;
    // retire acknowledged accesses
    for (int a = 0; a < 4; a++) begin
      if (s_r.mreq[a].valid && mem_rsp_i[a].ack) begin
        oc = s_r.own[a];
        s_nxt.mreq[a].valid = 1'b0;
        s_nxt.ch[oc].pend = 1'b0;
        hw = mem_rsp_i[a].rdata;
        // absent io location reads as all ones; an absent write retires
        // like any other and nothing in here keeps its data
        if (a == int'(adsp_pkg::AR_IO) && mem_rsp_i[a].absent && !s_r.mreq[a].we) begin
          hw = {`ADSP_ABSENT_BYTE, `ADSP_ABSENT_BYTE};
        end
        // pick the live lane of a partial access
        bt = (s_r.mreq[a].be == `ADSP_BE_HIGH) ? hw[15:8] : hw[7:0];
        if (s_r.mreq[a].be == `ADSP_BE_BOTH) begin
          s_nxt.ch[oc].racc = {s_r.ch[oc].racc[15:0], hw};
        end else begin
          s_nxt.ch[oc].racc = {s_r.ch[oc].racc[23:0], bt};
        end
        // last piece ends the transfer
        if (s_r.ch[oc].rem == 3'h0) begin
          s_nxt.ch[oc].busy = 1'b0;
          s_nxt.rsp[oc].done = 1'b1;
          s_nxt.rsp[oc].rdata = s_nxt.ch[oc].racc;
          s_nxt.rsp[oc].area = s_r.ch[oc].area;
          s_nxt.rsp[oc].resv = s_r.ch[oc].resv;
        end
      end
    end
    // issue, data channel wins a shared free target
    for (int c = 0; c < 2; c++) begin
      ar = s_r.ch[c].area;
      if (s_r.ch[c].busy && !s_r.ch[c].pend && s_r.ch[c].rem != 3'h0
          && !s_r.mreq[ar].valid && !s_nxt.mreq[ar].valid) begin
        cw = wide_of(s_r.ch[c].addr, ext_wide_i);
        two = cw && !s_r.ch[c].addr[0] && s_r.ch[c].rem >= 3'h2;
        s_nxt.mreq[ar].valid = 1'b1;
        s_nxt.mreq[ar].we = s_r.ch[c].we;
        s_nxt.mreq[ar].addr = s_r.ch[c].addr;
        s_nxt.own[ar] = c[0];
        s_nxt.ch[c].pend = 1'b1;
        if (two) begin
          s_nxt.mreq[ar].be = `ADSP_BE_BOTH;
          s_nxt.mreq[ar].wdata = s_r.ch[c].wsh[31:16];
          s_nxt.ch[c].wsh = {s_r.ch[c].wsh[15:0], 16'h0000};
          s_nxt.ch[c].addr = s_r.ch[c].addr + 24'h00_0002;
          s_nxt.ch[c].rem = s_r.ch[c].rem - 3'h2;
        end else begin
          // odd byte sits in the low lane; narrow targets use low lane only
          if (cw && !s_r.ch[c].addr[0]) begin
            s_nxt.mreq[ar].be = `ADSP_BE_HIGH;
          end else begin
            s_nxt.mreq[ar].be = `ADSP_BE_LOW;
          end
          s_nxt.mreq[ar].wdata = {s_r.ch[c].wsh[31:24], s_r.ch[c].wsh[31:24]};
          s_nxt.ch[c].wsh = {s_r.ch[c].wsh[23:0], 8'h00};
          s_nxt.ch[c].addr = s_r.ch[c].addr + 24'h00_0001;
          s_nxt.ch[c].rem = s_r.ch[c].rem - 3'h1;
        end
      end
    end
    // take new transfers on idle channels
    for (int c = 0; c < 2; c++) begin
      if (!s_r.ch[c].busy && cpu_req_i[c].valid) begin
        s_nxt.ch[c].busy = 1'b1;
        s_nxt.ch[c].pend = 1'b0;
        s_nxt.ch[c].area = area_of(cpu_req_i[c].addr);
        s_nxt.ch[c].resv = resv_of(cpu_req_i[c].addr);
        s_nxt.ch[c].we = cpu_req_i[c].we;
        s_nxt.ch[c].addr = cpu_req_i[c].addr;
        s_nxt.ch[c].rem = bytes_of(cpu_req_i[c].size);
        s_nxt.ch[c].racc = 32'h0000_0000;
        // left-justify so the most significant byte leaves first
        case (cpu_req_i[c].size)
          adsp_pkg::SZ_BYTE: s_nxt.ch[c].wsh = {cpu_req_i[c].wdata[7:0], 24'h00_0000};
          adsp_pkg::SZ_WORD: s_nxt.ch[c].wsh = {cpu_req_i[c].wdata[15:0], 16'h0000};
          default: s_nxt.ch[c].wsh = cpu_req_i[c].wdata;
        endcase
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from flip-flops
  assign cpu_busy_o = {s_r.ch[1].busy, s_r.ch[0].busy};
  assign cpu_rsp_o = s_r.rsp;
  assign mem_req_o = s_r.mreq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // helper: access count, expected count and start per channel
  logic [2:0] chk_cnt_r [2];
  logic [2:0] chk_exp_r [2];
  logic [23:0] chk_start_r [2];
  logic [1:0] chk_wide_r;

  // counts issues since each transfer was taken
  always_ff @(posedge mclk_i) begin
    for (int c = 0; c < 2; c++) begin
      if (!rst_n_i) begin
        chk_cnt_r[c] <= 3'h0;
        chk_exp_r[c] <= 3'h0;
        chk_start_r[c] <= 24'h00_0000;
        chk_wide_r[c] <= 1'b0;
      end else if (!s_r.ch[c].busy && cpu_req_i[c].valid) begin
        chk_cnt_r[c] <= 3'h0;
        chk_wide_r[c] <= wide_of(cpu_req_i[c].addr, ext_wide_i);
        chk_exp_r[c] <= cycles_of(cpu_req_i[c].size, cpu_req_i[c].addr[0],
                                  wide_of(cpu_req_i[c].addr, ext_wide_i));
        chk_start_r[c] <= cpu_req_i[c].addr;
      end else if (!s_r.ch[c].pend && s_nxt.ch[c].pend) begin
        chk_cnt_r[c] <= chk_cnt_r[c] + 3'h1;
      end
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  chk_io_route: assert property (
    s_r.mreq[2].valid |-> s_r.mreq[2].addr >= `ADSP_IO_BASE)
    else $error("io target saw an address below the io region");

  chk_ram_route: assert property (
    s_r.mreq[1].valid |-> (s_r.mreq[1].addr <= `ADSP_RAM_TOP
                           && s_r.mreq[1].addr >= `ADSP_RAM_BASE))
    else $error("ram target saw an address outside ram");

  chk_ext_route: assert property (
    s_r.mreq[3].valid |-> (s_r.mreq[3].addr < `ADSP_IO_BASE
      && !(s_r.mreq[3].addr <= `ADSP_NVM_TOP)
      && !(s_r.mreq[3].addr <= `ADSP_RAM_TOP && s_r.mreq[3].addr >= `ADSP_RAM_BASE)))
    else $error("external target saw an internal address");

  // absent places sit on narrow io, so only the low byte is certain to be pushed
  chk_absent_ones: assert property (
    (s_r.mreq[2].valid && mem_rsp_i[2].ack && mem_rsp_i[2].absent
     && !s_r.mreq[2].we)
    |=> s_r.ch[$past(s_r.own[2])].racc[7:0] == `ADSP_ABSENT_BYTE)
    else $error("absent io read did not return all ones");

  chk_even_count: assert property (
    (s_r.rsp[0].done && chk_wide_r[0] && !chk_start_r[0][0])
    |-> chk_cnt_r[0] == chk_exp_r[0])
    else $error("aligned transfer used the wrong number of accesses");

  chk_odd_count: assert property (
    (s_r.rsp[1].done && chk_wide_r[1] && chk_start_r[1][0])
    |-> chk_cnt_r[1] == chk_exp_r[1])
    else $error("unaligned transfer used the wrong number of accesses");

  chk_narrow_count: assert property (
    (s_r.rsp[0].done && !chk_wide_r[0]) |-> chk_cnt_r[0] == chk_exp_r[0])
    else $error("narrow transfer used the wrong number of accesses");

  chk_msb_first: assert property (
    (s_r.ch[0].busy && !s_r.ch[0].pend && s_nxt.ch[0].pend && chk_cnt_r[0] == 3'h0)
    ##1 1'b1 |-> s_r.mreq[s_r.ch[0].area].addr == chk_start_r[0])
    else $error("first access did not start at the transfer address");

  chk_odd_lane: assert property (
    (s_r.mreq[0].valid && s_r.mreq[0].addr[0]) |-> s_r.mreq[0].be == `ADSP_BE_LOW)
    else $error("odd nvm access used the wrong lane");

  chk_parallel_go: assert property (
    (s_r.ch[0].busy && s_r.ch[1].busy && !s_r.ch[0].pend && !s_r.ch[1].pend
     && s_r.ch[0].rem != 3'h0 && s_r.ch[1].rem != 3'h0
     && s_r.ch[0].area != s_r.ch[1].area
     && !s_r.mreq[s_r.ch[0].area].valid && !s_r.mreq[s_r.ch[1].area].valid)
    |=> (s_r.ch[0].pend && s_r.ch[1].pend))
    else $error("two free areas were not served in parallel");

  // a target must see the same cycle until it answers
  chk_req_hold: assert property (
    (s_r.mreq[0].valid && !mem_rsp_i[0].ack) |=> (s_r.mreq[0].valid
      && $stable(s_r.mreq[0].addr) && $stable(s_r.mreq[0].be)))
    else $error("nvm request changed before its ack");

  // both lanes only ever start at an even address
  chk_wide_pair: assert property (
    (s_r.mreq[1].valid && s_r.mreq[1].be == `ADSP_BE_BOTH) |-> !s_r.mreq[1].addr[0])
    else $error("ram paired access started at an odd address");

  // a narrow external bus only carries the low lane
  chk_ext_narrow: assert property (
    (s_r.mreq[3].valid && !ext_wide_i) |-> s_r.mreq[3].be == `ADSP_BE_LOW)
    else $error("narrow external bus saw a high lane");

  // byte peripherals are reached on the low lane only
  chk_io_narrow: assert property (
    (s_r.mreq[2].valid && !(s_r.mreq[2].addr >= `ADSP_IO_WIDE_LO
     && s_r.mreq[2].addr <= `ADSP_IO_WIDE_HI)) |-> s_r.mreq[2].be == `ADSP_BE_LOW)
    else $error("narrow io access used the high lane");

  // a partial write carries its byte on both lanes
  chk_byte_copy: assert property (
    (s_r.mreq[0].valid && s_r.mreq[0].we && s_r.mreq[0].be != `ADSP_BE_BOTH)
    |-> s_r.mreq[0].wdata[15:8] == s_r.mreq[0].wdata[7:0])
    else $error("partial nvm write did not copy its byte");

endmodule

`default_nettype wire

// File: src/adsp_consts.svh
// named constants of the address decode and access splitter
// assumes a 24-bit byte address and big-endian byte numbering
`ifndef ADSP_CONSTS_SVH
`define ADSP_CONSTS_SVH

// ----------------------------------------
// address map
// ----------------------------------------
`define ADSP_NVM_TOP 24'h01_ffff
`define ADSP_RAM_TOP 24'hff_bfff
`define ADSP_RAM_BASE 24'hff_8000
`define ADSP_IO_BASE 24'hff_e000
`define ADSP_IO_WIDE_LO 24'hff_e100
`define ADSP_IO_WIDE_HI 24'hff_e1ff

// ----------------------------------------
// reserved nonvolatile block, last byte of each slot
// ----------------------------------------
`define ADSP_OPT_END 24'h00_0003
`define ADSP_RST_END 24'h00_0007
`define ADSP_SYSX_END 24'h00_000b
`define ADSP_TRAP_END 24'h00_000f
`define ADSP_IRQ_END 24'h00_006f

// ----------------------------------------
// lanes, fills and channels
// ----------------------------------------
`define ADSP_BE_BOTH 2'h3
`define ADSP_BE_HIGH 2'h2
`define ADSP_BE_LOW 2'h1
`define ADSP_ABSENT_BYTE 8'hff
`define ADSP_CH_FETCH 1
`define ADSP_CH_DATA 0

`endif

// File: src/adsp_pkg.sv
// types shared by the address decode and access splitter
// assumes nothing beyond a 24-bit address and 32-bit cpu data
package adsp_pkg;

  // transfer size from the core
  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_QUAD = 2'b10
  } adsp_size_type;

  // memory areas, also the index of the target port
  typedef enum logic [1:0] {
    AR_NVM = 2'b00,
    AR_RAM = 2'b01,
    AR_IO = 2'b10,
    AR_EXT = 2'b11
  } adsp_area_type;

  // slot of the reserved nonvolatile block
  typedef enum logic [2:0] {
    RV_NONE = 3'b000,
    RV_OPTION = 3'b001,
    RV_RESET = 3'b010,
    RV_SYSEXC = 3'b011,
    RV_TRAP = 3'b100,
    RV_IRQ = 3'b101
  } adsp_resv_type;

  // request from one core channel
  typedef struct packed {
    logic valid;
    logic we;
    adsp_size_type size;
    logic [23:0] addr;
    logic [31:0] wdata;
  } adsp_cpu_req_type;

  // answer to one core channel
  typedef struct packed {
    logic done;
    logic [31:0] rdata;
    adsp_area_type area;
    adsp_resv_type resv;
  } adsp_cpu_rsp_type;

  // one bus cycle to a target, be[1] is the even (high) byte
  typedef struct packed {
    logic valid;
    logic we;
    logic [23:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } adsp_mem_req_type;

  // target reply
  typedef struct packed {
    logic ack;
    logic absent;
    logic [15:0] rdata;
  } adsp_mem_rsp_type;

  // per channel sequencing state
  typedef struct packed {
    logic busy;
    logic pend;
    adsp_area_type area;
    adsp_resv_type resv;
    logic we;
    logic [23:0] addr;
    logic [2:0] rem;
    logic [31:0] wsh;
    logic [31:0] racc;
  } adsp_chan_type;

  // module state apart from the check helpers
  typedef struct packed {
    adsp_chan_type [1:0] ch;
    adsp_mem_req_type [3:0] mreq;
    logic [3:0] own;
    adsp_cpu_rsp_type [1:0] rsp;
  } adsp_state_type;

endpackage

// File: tb/adsp_mem_model.sv
// partner memory standing behind one target port of the splitter
// assumes a single access outstanding per port and byte-addressed storage
`include "adsp_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module adsp_mem_model #(
  parameter int AREA = 0,
  parameter int SEED = 1,
  parameter logic [23:0] HOLE = 24'hff_f000
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // target port from the splitter
  input wire adsp_pkg::adsp_mem_req_type req_i,
  output adsp_pkg::adsp_mem_rsp_type rsp_o,
  // width and pacing
  input wire logic wide_i,
  input wire logic slow_i
);
  // ----------------------------------------
  // storage and decode
  // ----------------------------------------
  logic [7:0] mem [int]; // bytes written so far
  int seed_r = SEED; // stall pattern source
  logic [23:0] ev; // even byte of the addressed pair
  logic absent; // unimplemented io location
  logic wide; // this access sees a 16-bit target
  assign ev = {req_i.addr[23:1], 1'b0};
  assign absent = (AREA == 2) && (req_i.addr >= HOLE);
  // io width depends on the peripheral
  assign wide = (AREA == 2) ? (req_i.addr >= `ADSP_IO_WIDE_LO &&
                req_i.addr <= `ADSP_IO_WIDE_HI) : wide_i;

  // unwritten bytes read back an address pattern
  function automatic logic [7:0] rd(input logic [23:0] a);
    return mem.exists(a) ? mem[a] : (a[7:0] ^ 8'h5a);
  endfunction

  // answer a cycle or more after valid; released data keeps toggling
  always @(posedge mclk_i) begin
    rsp_o.rdata <= rst_n_i ? ~rsp_o.rdata : 16'h0000;
    rsp_o.ack <= 1'b0;
    rsp_o.absent <= 1'b0;
    if (rst_n_i && req_i.valid && !rsp_o.ack && !(slow_i && ($random(seed_r) & 3) != 0)) begin
      rsp_o.ack <= 1'b1;
      rsp_o.absent <= absent;
      if (absent) begin
        rsp_o.rdata <= 16'h1234; // junk, the splitter must fill ones
      end else if (!wide) begin // one byte on the low lane
        if (req_i.we) mem[req_i.addr] = req_i.wdata[7:0];
        rsp_o.rdata <= {~rd(req_i.addr), rd(req_i.addr)};
      end else begin // even byte on the high lane
        if (req_i.we && req_i.be[1]) mem[ev] = req_i.wdata[15:8];
        if (req_i.we && req_i.be[0]) mem[ev | 24'h1] = req_i.wdata[7:0];
        rsp_o.rdata <= {rd(ev), rd(ev | 24'h1)};
      end
    end
  end
endmodule

`default_nettype wire

// File: tb/adsp_splitter_tb_top.sv
// self-checking bench for the splitter against a byte-level model
// assumes the four partner memories answer on every target port
`include "adsp_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module adsp_splitter_tb_top;
  localparam logic [23:0] HOLE = 24'hff_f000; // start of absent io
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  adsp_pkg::adsp_cpu_req_type [1:0] cpu_req_i = '0;
  logic [1:0] cpu_busy_o;
  adsp_pkg::adsp_cpu_rsp_type [1:0] cpu_rsp_o;
  adsp_pkg::adsp_mem_req_type [3:0] mem_req_o;
  wire adsp_pkg::adsp_mem_rsp_type [3:0] mem_rsp_i; // one partner drives each element
  logic ext_wide_i = 1'b1;
  logic slow = 1'b0; // partner stalls when high
  int n_mismatch = 0;
  int total_checks = 0;
  int seed = 86;
  int pieces [4] = '{default: 0}; // bus cycles per target this transfer
  logic [3:0] vld_q = '0;
  logic both_seen = 1'b0; // nvm and ram busy together
  logic [7:0] ref_mem [int]; // expected contents
  logic [23:0] edges [16] = '{24'h00_0000, 24'h00_0004, 24'h00_0008, 24'h00_000c,
    24'h00_0010, 24'h00_006f, 24'h00_0070, 24'h01_ffff, 24'h02_0000, 24'hff_7fff,
    24'hff_8000, 24'hff_bfff, 24'hff_c000, 24'hff_dfff, 24'hff_e000, 24'hff_ffff};
  logic [23:0] bases [5] = '{24'h00_0200, 24'hff_9000, 24'hff_e300, 24'hff_e140,
    24'h40_0000};

  always #5 mclk_i = ~mclk_i;

  adsp_splitter i_adsp_splitter (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cpu_req_i(cpu_req_i),
    .cpu_busy_o(cpu_busy_o), .cpu_rsp_o(cpu_rsp_o), .mem_req_o(mem_req_o),
    .mem_rsp_i(mem_rsp_i), .ext_wide_i(ext_wide_i));

  for (genvar g = 0; g < 4; g++) begin : g_tgt
    adsp_mem_model #(.AREA(g), .SEED(g + 7), .HOLE(HOLE)) i_adsp_mem_model (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(mem_req_o[g]), .rsp_o(mem_rsp_i[g]),
      .wide_i(g == 3 ? ext_wide_i : 1'b1), .slow_i(slow));
  end

  // ----------------------------------------
  // observation and reference
  // ----------------------------------------
  // count rising valids; a piece always has a low cycle between
  always @(posedge mclk_i) begin
    for (int a = 0; a < 4; a++) begin
      if (mem_req_o[a].valid && !vld_q[a]) pieces[a]++;
      vld_q[a] <= mem_req_o[a].valid;
    end
    if (mem_req_o[0].valid && mem_req_o[1].valid) both_seen <= 1'b1;
  end

  function automatic int area_of(input logic [23:0] a);
    if (a <= `ADSP_NVM_TOP) return 0;
    if (a >= `ADSP_RAM_BASE && a <= `ADSP_RAM_TOP) return 1;
    return a >= `ADSP_IO_BASE ? 2 : 3;
  endfunction

  function automatic logic wide_of(input logic [23:0] a);
    int ar;
    ar = area_of(a);
    if (ar == 2) return a >= `ADSP_IO_WIDE_LO && a <= `ADSP_IO_WIDE_HI;
    return ar == 3 ? ext_wide_i : 1'b1;
  endfunction

  function automatic logic [7:0] ref_rd(input logic [23:0] a);
    if (a >= HOLE) return 8'hff;
    return ref_mem.exists(a) ? ref_mem[a] : (a[7:0] ^ 8'h5a);
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one whole transfer on channel c, then compare everything it showed
  task automatic xfer(input int c, input logic we, input int s, input logic [23:0] a,
                      input logic [31:0] wd);
    int n;
    int k;
    int ar;
    int rv;
    logic [31:0] exp;
    n = s == 0 ? 1 : s == 1 ? 2 : 4;
    ar = area_of(a);
    rv = a <= 24'h3 ? 1 : a <= 24'h7 ? 2 : a <= 24'hb ? 3 : a <= 24'hf ? 4 : a <= 24'h6f ? 5 : 0;
    exp = '0;
    pieces[ar] = 0;
    cpu_req_i[c] <= '{1'b1, we, adsp_pkg::adsp_size_type'(2'(s)), a, wd};
    k = 0;
    do begin @(posedge mclk_i); k++; end while (cpu_busy_o[c] !== 1'b0 && k < 50);
    cpu_req_i[c].valid <= 1'b0;
    k = 0;
    do begin @(posedge mclk_i); k++; end while (cpu_rsp_o[c].done !== 1'b1 && k < 300);
    check("done", 32'h1, 32'(k < 300));
    for (int i = 0; i < n; i++) begin
      if (we) ref_mem[a + i] = wd[8 * (n - 1 - i) +: 8];
      exp = {exp[23:0], ref_rd(a + 24'(i))};
    end
    if (!we) check("rdata", exp, cpu_rsp_o[c].rdata);
    check("area", 32'(ar), 32'(cpu_rsp_o[c].area));
    check("resv", 32'(rv), 32'(cpu_rsp_o[c].resv));
    k = wide_of(a) ? ((int'(a) + n - 1) >> 1) - (int'(a) >> 1) + 1 : n;
    check("pieces", 32'(k), 32'(pieces[ar]));
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    foreach (edges[i]) xfer(i % 2, 1'b0, 0, edges[i], 32'h0);
    $display("test map ends");
    for (int w = 0; w < 2; w++) begin
      ext_wide_i <= w[0];
      foreach (bases[j]) for (int o = 0; o < 2; o++) for (int s = 1; s < 3; s++) begin
        xfer(0, 1'b1, s, bases[j] + 24'(o), $random(seed));
        xfer(1, 1'b0, s, bases[j] + 24'(o), 32'h0);
      end
    end
    $display("test widths ends");
    xfer(0, 1'b1, 2, HOLE + 24'h1, 32'h0102_0304);
    xfer(1, 1'b0, 2, HOLE + 24'h1, 32'h0);
    $display("test absent io ends");
    fork
      xfer(1, 1'b0, 2, 24'h00_0301, 32'h0);
      xfer(0, 1'b0, 2, 24'hff_9101, 32'h0);
    join
    check("parallel", 32'h1, 32'(both_seen));
    $display("test parallel ends");
    // io writes land only on plain storage, never on an absent place
    for (int i = 0; i < 60; i++) begin
      r = $random(seed);
      slow <= r[8];
      ext_wide_i <= r[9];
      xfer(r[11] ? 0 : int'(r[10]), r[11], r[13:12] == 2'h3 ? 2 : int'(r[13:12]),
           bases[r[16:14] % 5] + 24'(r[6:0]), $random(seed));
    end
    $display("test random ends");
    summarize();
  end

  // cut a hang short after 50,000 cycles, well past the length of a normal run
  initial begin
    #500_000;
    n_mismatch++;
    summarize();
  end
endmodule

`default_nettype wire
